// *** hdl/fas_pkg.sv ***
// Constants shared by the flash access and security block
package fas_pkg;

	// ------------------------------------------------------------
	// Register byte offsets on the bus
	// ------------------------------------------------------------
	localparam logic [4:0] OFS_PAGE_DATA0 = 5'h00;
	localparam logic [4:0] OFS_PAGE_DATA1 = 5'h04;
	localparam logic [4:0] OFS_PAGE_DATA2 = 5'h08;
	localparam logic [4:0] OFS_PAGE_DATA3 = 5'h0C;
	localparam logic [4:0] OFS_PAGE_ADDR_HIGH = 5'h10;
	localparam logic [4:0] OFS_PAGE_ADDR_LOW = 5'h14;
	localparam logic [4:0] OFS_FLASH_COMMAND = 5'h18;
	localparam logic [4:0] OFS_STATUS = 5'h1C;

	// ------------------------------------------------------------
	// Status register fields
	// ------------------------------------------------------------
	localparam int ST_USER_WR_MODE = 0;
	localparam int ST_LOCK = 1;
	localparam int ST_SECURE = 2;
	localparam int ST_SERIAL_SAFE = 3;
	localparam int ST_DOWNLOAD = 4;
	localparam int ST_REFUSED = 5;

	// ------------------------------------------------------------
	// Memory sizes in bytes
	// ------------------------------------------------------------
	localparam int PROG_BYTES = 63488;
	localparam int USER_PROG_BYTES = 57344;
	localparam int DATA_BYTES = 4096;
	localparam int PAGE_BYTES = 4;
	localparam int PROG_PAGE_BYTES = 64;

	// ------------------------------------------------------------
	// Commands
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_READ = 8'h01;
	localparam logic [7:0] CMD_WRITE = 8'h02;
	localparam logic [7:0] CMD_VERIFY = 8'h04;
	localparam logic [7:0] CMD_ERASE_PAGE = 8'h05;
	localparam logic [7:0] CMD_ERASE_ALL = 8'h06;
	localparam logic [7:0] CMD_READ_BYTE = 8'h81;
	localparam logic [7:0] CMD_WRITE_BYTE = 8'h82;
	localparam logic [7:0] CMD_LEAVE_USER_WRITE = 8'h0F;
	localparam logic [7:0] CMD_USER_PROGRAM_WRITE = 8'hF0;
	localparam logic [7:0] VERIFY_FAIL = 8'h01;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	localparam logic [7:0] FLASH_COMMAND_RESET = 8'h00;

	// ------------------------------------------------------------
	// Operations on the programming config port and downloader
	// ------------------------------------------------------------
	localparam logic [1:0] OP_PROGRAM = 2'h0;
	localparam logic [1:0] OP_READ = 2'h1;
	localparam logic [1:0] OP_CODE_ERASE = 2'h2;
	localparam logic [1:0] OP_SET_SECURITY = 2'h3;

endpackage : fas_pkg

// *** hdl/fas_flash_ctrl.sv ***
// Flash access control, security flags and data store register window
//
// How it works
// - Low fetch strobe at reset enters download mode
// - Parallel port: address, data, strobe, operation select
// - Program store sits at address zero
// - Program store read-only to software outside user-write mode
// - User-write mode writes lower 56 kB only
// - Top 6 kB never written by software
// - Lock, secure, serial-safe are independent flags
// - Lock refuses parallel program operations
// - Lock alone still allows parallel and external reads
// - Code erase clears lock and secure
// - Secure blocks parallel access and external code reads
// - Secure blocks data store from external code
// - Serial-safe turns download reset into normal reset
// - Only parallel code erase or power-on reset clears serial-safe
// - Data store: 1024 pages of 4 bytes
// - Four page data registers
// - Page address in high and low registers
// - Command register triggers nine commands
// - One command register serves both stores
// - Read command loads page into data registers
// - Verify leaves zero on match, nonzero otherwise
// - F0 enters user-write mode, 0F leaves it
module fas_flash_ctrl
(
	// Clock and resets
	input wire logic sys_clk_in,
	input wire logic reset_in,
	input wire logic por_in,
	// Avalon-MM register slave
	input wire logic [4:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	// Boot strap and mode
	input wire logic code_fetch_strobe_pin_in,
	output logic download_mode_out,
	// Core context and code-space reads
	input wire logic ext_exec_in,
	input wire logic code_rd_in,
	input wire logic [15:0] code_addr_in,
	output logic [7:0] code_data_out,
	output logic code_blocked_out,
	// Parallel programming port
	input wire logic pp_enable_in,
	input wire logic [15:0] pp_addr_in,
	input wire logic [7:0] pp_data_in,
	input wire logic pp_write_strobe_in,
	input wire logic [1:0] programming_config_port_in,
	output logic [7:0] pp_rdata_out,
	output logic pp_refused_out,
	// Serial downloader command port
	input wire logic dl_valid_in,
	input wire logic [1:0] dl_op_in,
	input wire logic [15:0] dl_addr_in,
	input wire logic [7:0] dl_data_in
);

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	logic [7:0] prog_mem [fas_pkg::PROG_BYTES];
	logic [7:0] data_mem [fas_pkg::DATA_BYTES];
	logic [7:0] page_data_regs_q [4];
	logic [7:0] page_addr_high_q;
	logic [7:0] page_addr_low_q;
	logic [7:0] flash_command_q;
	logic user_program_write_mode_q;
	logic refused_q;
	logic lock_q;
	logic secure_q;
	logic serial_safe_q;
	logic download_mode_q;
	logic wait_q;
	logic [31:0] readdata_q;
	logic [7:0] code_data_q;
	logic code_blocked_q;
	logic [7:0] pp_rdata_q;
	logic pp_refused_q;

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	logic wr_take;
	logic rd_early;
	logic cmd_go;
	logic [7:0] cmd;
	logic data_ok;
	logic norm;
	logic [9:0] page_idx;
	logic [11:0] byte_addr;
	logic [15:0] prog_addr;
	logic page_match;
	logic d_read_page;
	logic d_write_page;
	logic d_erase_page;
	logic d_erase_all;
	logic d_read_byte;
	logic d_write_byte;
	logic d_verify;
	logic p_erase_page;
	logic p_erase_all;
	logic p_write_byte;
	logic pp_go;
	logic dl_go;

	function automatic logic in_user_region(input logic [15:0] a);
		in_user_region = 32'(a) < fas_pkg::USER_PROG_BYTES;
	endfunction : in_user_region

	function automatic logic in_prog_store(input logic [15:0] a);
		in_prog_store = 32'(a) < fas_pkg::PROG_BYTES;
	endfunction : in_prog_store

	assign wr_take = avs_write_in && !wait_q;
	assign rd_early = avs_read_in && wait_q;
	assign cmd_go = wr_take && avs_address_in == fas_pkg::OFS_FLASH_COMMAND;
	assign cmd = avs_writedata_in[7:0];
	assign data_ok = !(secure_q && ext_exec_in);
	assign norm = !user_program_write_mode_q;
	assign page_idx = {page_addr_high_q[1:0], page_addr_low_q};
	assign byte_addr = {page_addr_high_q[3:0], page_addr_low_q};
	assign prog_addr = {page_addr_high_q, page_addr_low_q};
	assign pp_go = pp_enable_in && pp_write_strobe_in;
	assign dl_go = dl_valid_in && download_mode_q;

	always_comb
	begin
		page_match = 1'b1;
		for (int i = 0; i < fas_pkg::PAGE_BYTES; i++)
		begin
			if (data_mem[{page_idx, 2'(i)}] != page_data_regs_q[i])
			begin
				page_match = 1'b0;
			end
		end
	end

	// Data store commands, normal mode only
	assign d_read_page = cmd_go && norm && data_ok && cmd == fas_pkg::CMD_READ;
	assign d_write_page = cmd_go && norm && data_ok &&
		cmd == fas_pkg::CMD_WRITE;
	assign d_erase_page = cmd_go && norm && data_ok &&
		cmd == fas_pkg::CMD_ERASE_PAGE;
	assign d_erase_all = cmd_go && norm && data_ok &&
		cmd == fas_pkg::CMD_ERASE_ALL;
	assign d_read_byte = cmd_go && norm && data_ok &&
		cmd == fas_pkg::CMD_READ_BYTE;
	assign d_write_byte = cmd_go && norm && data_ok &&
		cmd == fas_pkg::CMD_WRITE_BYTE;
	assign d_verify = cmd_go && norm && data_ok &&
		cmd == fas_pkg::CMD_VERIFY;

	// Program store commands, user-write mode only, lower region only
	assign p_erase_page = cmd_go && !norm && in_user_region(prog_addr) &&
		cmd == fas_pkg::CMD_ERASE_PAGE;
	assign p_erase_all = cmd_go && !norm && cmd == fas_pkg::CMD_ERASE_ALL;
	assign p_write_byte = cmd_go && !norm && in_user_region(prog_addr) &&
		cmd == fas_pkg::CMD_WRITE_BYTE;

	// ------------------------------------------------------------
	// Bus handshake and read data
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_in)
	begin
		if (reset_in)
		begin
			wait_q <= 1'b1;
		end
		else
		begin
			wait_q <= !(wait_q && (avs_read_in || avs_write_in));
		end
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (reset_in)
		begin
			readdata_q <= 32'h0000_0000;
		end
		else if (rd_early)
		begin
			readdata_q <= 32'h0000_0000;
			unique case (avs_address_in)
				fas_pkg::OFS_PAGE_DATA0:
					readdata_q[7:0] <= page_data_regs_q[0];
				fas_pkg::OFS_PAGE_DATA1:
					readdata_q[7:0] <= page_data_regs_q[1];
				fas_pkg::OFS_PAGE_DATA2:
					readdata_q[7:0] <= page_data_regs_q[2];
				fas_pkg::OFS_PAGE_DATA3:
					readdata_q[7:0] <= page_data_regs_q[3];
				fas_pkg::OFS_PAGE_ADDR_HIGH:
					readdata_q[7:0] <= page_addr_high_q;
				fas_pkg::OFS_PAGE_ADDR_LOW:
					readdata_q[7:0] <= page_addr_low_q;
				fas_pkg::OFS_FLASH_COMMAND:
					readdata_q[7:0] <= flash_command_q;
				fas_pkg::OFS_STATUS:
				begin
					readdata_q[fas_pkg::ST_USER_WR_MODE] <=
						user_program_write_mode_q;
					readdata_q[fas_pkg::ST_LOCK] <= lock_q;
					readdata_q[fas_pkg::ST_SECURE] <= secure_q;
					readdata_q[fas_pkg::ST_SERIAL_SAFE] <= serial_safe_q;
					readdata_q[fas_pkg::ST_DOWNLOAD] <= download_mode_q;
					readdata_q[fas_pkg::ST_REFUSED] <= refused_q;
				end
				default:
					readdata_q <= 32'h0000_0000;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Register window and command register
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_in)
	begin
		if (reset_in)
		begin
			for (int i = 0; i < fas_pkg::PAGE_BYTES; i++)
			begin
				page_data_regs_q[i] <= 8'h00;
			end
			page_addr_high_q <= 8'h00;
			page_addr_low_q <= 8'h00;
		end
		else if (d_read_page)
		begin
			for (int i = 0; i < fas_pkg::PAGE_BYTES; i++)
			begin
				page_data_regs_q[i] <= data_mem[{page_idx, 2'(i)}];
			end
		end
		else if (d_read_byte)
		begin
			page_data_regs_q[0] <= data_mem[byte_addr];
		end
		else if (wr_take)
		begin
			unique case (avs_address_in)
				fas_pkg::OFS_PAGE_DATA0:
					page_data_regs_q[0] <= avs_writedata_in[7:0];
				fas_pkg::OFS_PAGE_DATA1:
					page_data_regs_q[1] <= avs_writedata_in[7:0];
				fas_pkg::OFS_PAGE_DATA2:
					page_data_regs_q[2] <= avs_writedata_in[7:0];
				fas_pkg::OFS_PAGE_DATA3:
					page_data_regs_q[3] <= avs_writedata_in[7:0];
				fas_pkg::OFS_PAGE_ADDR_HIGH:
					page_addr_high_q <= avs_writedata_in[7:0];
				fas_pkg::OFS_PAGE_ADDR_LOW:
					page_addr_low_q <= avs_writedata_in[7:0];
				default:
				begin
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (reset_in)
		begin
			flash_command_q <= fas_pkg::FLASH_COMMAND_RESET;
			refused_q <= 1'b0;
		end
		else if (cmd_go)
		begin
			flash_command_q <= cmd;
			refused_q <= norm && !data_ok;
			if (d_verify)
			begin
				flash_command_q <= page_match ? 8'h00 : fas_pkg::VERIFY_FAIL;
			end
		end
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (reset_in)
		begin
			user_program_write_mode_q <= 1'b0;
		end
		else if (cmd_go && cmd == fas_pkg::CMD_USER_PROGRAM_WRITE)
		begin
			user_program_write_mode_q <= 1'b1;
		end
		else if (cmd_go && cmd == fas_pkg::CMD_LEAVE_USER_WRITE)
		begin
			user_program_write_mode_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Data store array, programming only clears bits
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_in)
	begin
		if (d_erase_all)
		begin
			for (int i = 0; i < fas_pkg::DATA_BYTES; i++)
			begin
				data_mem[i] <= fas_pkg::ERASED_BYTE;
			end
		end
		else
		begin
			for (int i = 0; i < fas_pkg::PAGE_BYTES; i++)
			begin
				if (d_erase_page)
				begin
					data_mem[{page_idx, 2'(i)}] <= fas_pkg::ERASED_BYTE;
				end
				else if (d_write_page)
				begin
					data_mem[{page_idx, 2'(i)}] <=
						data_mem[{page_idx, 2'(i)}] & page_data_regs_q[i];
				end
			end
			if (d_write_byte)
			begin
				data_mem[byte_addr] <= data_mem[byte_addr] & page_data_regs_q[0];
			end
		end
	end

	// ------------------------------------------------------------
	// Program store array
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_in)
	begin
		if (pp_go && programming_config_port_in == fas_pkg::OP_CODE_ERASE ||
			dl_go && dl_op_in == fas_pkg::OP_CODE_ERASE)
		begin
			for (int i = 0; i < fas_pkg::PROG_BYTES; i++)
			begin
				prog_mem[i] <= fas_pkg::ERASED_BYTE;
			end
		end
		else if (p_erase_all)
		begin
			for (int i = 0; i < fas_pkg::USER_PROG_BYTES; i++)
			begin
				prog_mem[i] <= fas_pkg::ERASED_BYTE;
			end
		end
		else if (p_erase_page)
		begin
			for (int i = 0; i < fas_pkg::PROG_PAGE_BYTES; i++)
			begin
				prog_mem[{prog_addr[15:6], 6'(i)}] <= fas_pkg::ERASED_BYTE;
			end
		end
		else if (p_write_byte)
		begin
			prog_mem[prog_addr] <= prog_mem[prog_addr] & page_data_regs_q[0];
		end
		else if (pp_go && programming_config_port_in == fas_pkg::OP_PROGRAM &&
			!lock_q && !secure_q && in_prog_store(pp_addr_in))
		begin
			prog_mem[pp_addr_in] <= prog_mem[pp_addr_in] & pp_data_in;
		end
		else if (dl_go && dl_op_in == fas_pkg::OP_PROGRAM &&
			in_prog_store(dl_addr_in))
		begin
			prog_mem[dl_addr_in] <= prog_mem[dl_addr_in] & dl_data_in;
		end
	end

	// ------------------------------------------------------------
	// Security flags survive the core reset
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_in)
	begin
		if (por_in)
		begin
			lock_q <= 1'b0;
			secure_q <= 1'b0;
			serial_safe_q <= 1'b0;
		end
		else if (pp_go && programming_config_port_in == fas_pkg::OP_CODE_ERASE)
		begin
			lock_q <= 1'b0;
			secure_q <= 1'b0;
			serial_safe_q <= 1'b0;
		end
		else if (dl_go && dl_op_in == fas_pkg::OP_CODE_ERASE)
		begin
			lock_q <= 1'b0;
			secure_q <= 1'b0;
		end
		else if (pp_go &&
			programming_config_port_in == fas_pkg::OP_SET_SECURITY)
		begin
			lock_q <= lock_q | pp_data_in[0];
			secure_q <= secure_q | pp_data_in[1];
			serial_safe_q <= serial_safe_q | pp_data_in[2];
		end
		else if (dl_go && dl_op_in == fas_pkg::OP_SET_SECURITY)
		begin
			lock_q <= lock_q | dl_data_in[0];
			secure_q <= secure_q | dl_data_in[1];
			serial_safe_q <= serial_safe_q | dl_data_in[2];
		end
	end

	// Strap sampled while reset is held
	always_ff @(posedge sys_clk_in)
	begin
		if (reset_in)
		begin
			download_mode_q <= !code_fetch_strobe_pin_in && !serial_safe_q;
		end
	end

	// ------------------------------------------------------------
	// Parallel port and code-space reads
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_in)
	begin
		if (reset_in)
		begin
			pp_rdata_q <= 8'h00;
			pp_refused_q <= 1'b0;
		end
		else if (pp_enable_in)
		begin
			pp_refused_q <= pp_write_strobe_in &&
				programming_config_port_in == fas_pkg::OP_PROGRAM &&
				(lock_q || secure_q);
			if (programming_config_port_in == fas_pkg::OP_READ)
			begin
				pp_refused_q <= secure_q;
				pp_rdata_q <= (secure_q || !in_prog_store(pp_addr_in)) ?
					fas_pkg::ERASED_BYTE : prog_mem[pp_addr_in];
			end
		end
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (reset_in)
		begin
			code_data_q <= 8'h00;
			code_blocked_q <= 1'b0;
		end
		else if (code_rd_in)
		begin
			code_blocked_q <= secure_q && ext_exec_in;
			code_data_q <= (secure_q && ext_exec_in) ||
				!in_prog_store(code_addr_in) ?
				fas_pkg::ERASED_BYTE : prog_mem[code_addr_in];
		end
	end

	assign avs_readdata_out = readdata_q;
	assign avs_waitrequest_out = wait_q;
	assign download_mode_out = download_mode_q;
	assign code_data_out = code_data_q;
	assign code_blocked_out = code_blocked_q;
	assign pp_rdata_out = pp_rdata_q;
	assign pp_refused_out = pp_refused_q;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_boot_download;
		@(posedge sys_clk_in) disable iff (reset_in)
		$fell(reset_in) |->
			download_mode_q == ($past(!code_fetch_strobe_pin_in) &&
			!$past(serial_safe_q));
	endproperty
	a_boot_download: assert property (p_boot_download)
		else $error("download mode does not follow strap");

	property p_serial_safe_boot;
		@(posedge sys_clk_in) disable iff (reset_in)
		$fell(reset_in) && $past(serial_safe_q) |-> !download_mode_q;
	endproperty
	a_serial_safe_boot: assert property (p_serial_safe_boot)
		else $error("download entered with serial-safe set");

	property p_top_region_kept;
		@(posedge sys_clk_in) disable iff (reset_in)
		cmd_go && cmd == fas_pkg::CMD_WRITE_BYTE &&
			!in_user_region(prog_addr) && !pp_go && !dl_go
		|=> $stable(prog_mem[prog_addr]);
	endproperty
	a_top_region_kept: assert property (p_top_region_kept)
		else $error("software changed top program region");

	property p_lock_refuses;
		@(posedge sys_clk_in) disable iff (reset_in || por_in)
		pp_go && programming_config_port_in == fas_pkg::OP_PROGRAM && lock_q
		|=> pp_refused_out;
	endproperty
	a_lock_refuses: assert property (p_lock_refuses)
		else $error("program accepted while locked");

	property p_secure_code_read;
		@(posedge sys_clk_in) disable iff (reset_in || por_in)
		code_rd_in && secure_q && ext_exec_in
		|=> code_blocked_out && code_data_out == fas_pkg::ERASED_BYTE;
	endproperty
	a_secure_code_read: assert property (p_secure_code_read)
		else $error("external code read not blocked");

	property p_pp_erase_clears;
		@(posedge sys_clk_in) disable iff (por_in)
		pp_go && programming_config_port_in == fas_pkg::OP_CODE_ERASE
		|=> !lock_q && !secure_q && !serial_safe_q;
	endproperty
	a_pp_erase_clears: assert property (p_pp_erase_clears)
		else $error("parallel code erase left a flag set");

	property p_dl_keeps_safe;
		@(posedge sys_clk_in) disable iff (por_in)
		dl_go && dl_op_in == fas_pkg::OP_CODE_ERASE && serial_safe_q &&
			!pp_go
		|=> serial_safe_q && !lock_q;
	endproperty
	a_dl_keeps_safe: assert property (p_dl_keeps_safe)
		else $error("download erase cleared serial-safe");

	property p_verify_result;
		@(posedge sys_clk_in) disable iff (reset_in)
		d_verify |=> flash_command_q == ($past(page_match) ? 8'h00 :
			fas_pkg::VERIFY_FAIL);
	endproperty
	a_verify_result: assert property (p_verify_result)
		else $error("verify result wrong");

	property p_user_mode_enter;
		@(posedge sys_clk_in) disable iff (reset_in)
		cmd_go && cmd == fas_pkg::CMD_USER_PROGRAM_WRITE
		|=> user_program_write_mode_q ##1 1'b1;
	endproperty
	a_user_mode_enter: assert property (p_user_mode_enter)
		else $error("user-write mode not entered");

	property p_secure_data_block;
		@(posedge sys_clk_in) disable iff (reset_in)
		cmd_go && norm && secure_q && ext_exec_in
		|=> refused_q && $stable(page_data_regs_q[0]);
	endproperty
	a_secure_data_block: assert property (p_secure_data_block)
		else $error("data store reached from external code");

	c_verify_pass: cover property (@(posedge sys_clk_in)
		d_verify && page_match);
	c_user_write: cover property (@(posedge sys_clk_in) p_write_byte);
	c_pp_erase: cover property (@(posedge sys_clk_in)
		pp_go && programming_config_port_in == fas_pkg::OP_CODE_ERASE);

endmodule : fas_flash_ctrl

// *** test/fas_prog_host.sv ***
// Model of the external parallel programmer and serial downloader
module fas_prog_host
(
	// Clock
	input wire logic clk_in,
	// Parallel programming port
	output logic pp_enable_out = 1'b0,
	output logic [15:0] pp_addr_out = 16'h0000,
	output logic [7:0] pp_data_out = 8'h00,
	output logic pp_write_strobe_out = 1'b0,
	output logic [1:0] pp_op_out = 2'h1,
	// Serial downloader port
	output logic dl_valid_out = 1'b0,
	output logic [1:0] dl_op_out = 2'h1,
	output logic [15:0] dl_addr_out = 16'h0000,
	output logic [7:0] dl_data_out = 8'h00
);
	timeunit 1ns;
	timeprecision 1ps;

	task pp_op(input logic [1:0] op, input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_in);
		pp_enable_out <= 1'b1;
		pp_op_out <= op;
		pp_addr_out <= a;
		pp_data_out <= d;
		pp_write_strobe_out <= (op != fas_pkg::OP_READ);
		@(posedge clk_in);
		pp_enable_out <= 1'b0;
		pp_write_strobe_out <= 1'b0;
		pp_data_out <= ~d;
	endtask : pp_op

	task dl_cmd(input logic [1:0] op, input logic [7:0] d);
		@(posedge clk_in);
		dl_valid_out <= 1'b1;
		dl_op_out <= op;
		dl_data_out <= d;
		@(posedge clk_in);
		dl_valid_out <= 1'b0;
		dl_data_out <= ~d;
	endtask : dl_cmd
endmodule : fas_prog_host

// *** test/flash_access_and_security_test.sv ***
// Self-checking bench of the flash access and security block
`define CHK(g, e) \
	begin \
		checks_done++; \
		if ((g) !== (e)) \
		begin \
			$display("wrong value t=%0t %h %h", $time, g, e); \
			n_fail++; \
		end \
	end
module flash_access_and_security_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] ALL = 32'hFFFF_FFFF;
	logic clk = 1'b0, rst = 1'b1, por = 1'b1, rd = 1'b0, wr = 1'b0;
	logic strap = 1'b1, ext = 1'b0, crd = 1'b0;
	logic [4:0] adr = 5'h00;
	logic [31:0] wd = 32'h0000_0000, rdat, q;
	logic [15:0] cadr = 16'h0000, pp_a, dl_a;
	logic [7:0] cdat, pp_d, dl_d, pp_q;
	logic [1:0] pp_op, dl_op;
	logic wt, dl_mode, cblk, pp_en, pp_stb, dl_v, pp_ref;
	int n_fail = 0;
	int checks_done = 0;

	fas_flash_ctrl fas_flash_ctrl_inst
	(
		.sys_clk_in(clk), .reset_in(rst), .por_in(por),
		.avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
		.avs_writedata_in(wd), .avs_readdata_out(rdat),
		.avs_waitrequest_out(wt), .code_fetch_strobe_pin_in(strap),
		.download_mode_out(dl_mode), .ext_exec_in(ext), .code_rd_in(crd),
		.code_addr_in(cadr), .code_data_out(cdat), .code_blocked_out(cblk),
		.pp_enable_in(pp_en), .pp_addr_in(pp_a), .pp_data_in(pp_d),
		.pp_write_strobe_in(pp_stb), .programming_config_port_in(pp_op),
		.pp_rdata_out(pp_q), .pp_refused_out(pp_ref), .dl_valid_in(dl_v),
		.dl_op_in(dl_op), .dl_addr_in(dl_a), .dl_data_in(dl_d)
	);
	fas_prog_host fas_prog_host_inst
	(
		.clk_in(clk), .pp_enable_out(pp_en), .pp_addr_out(pp_a),
		.pp_data_out(pp_d), .pp_write_strobe_out(pp_stb), .pp_op_out(pp_op),
		.dl_valid_out(dl_v), .dl_op_out(dl_op), .dl_addr_out(dl_a),
		.dl_data_out(dl_d)
	);

	initial
		forever
			#5 clk = ~clk;

	task print_verdict;
		$display("checks %0d, failures %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : print_verdict

	initial
	begin
		#100000;
		n_fail++;
		print_verdict();
	end

	// ------------------------------------------------------------
	// Bus, port and reset helpers
	// ------------------------------------------------------------
	task bus(input logic w, input logic [4:0] a, input logic [7:0] d);
		@(posedge clk);
		adr <= a;
		wd <= {24'h00_0000, d};
		wr <= w;
		rd <= !w;
		@(posedge clk);
		while (wt !== 1'b0)
			@(posedge clk);
		q = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask : bus

	task rd_chk(input logic [4:0] a, input logic [31:0] m, e);
		bus(1'b0, a, 8'h00);
		`CHK(q & m, e)
	endtask : rd_chk

	task cmd(input logic [7:0] c);
		bus(1'b1, fas_pkg::OFS_FLASH_COMMAND, c);
	endtask : cmd

	task page(input logic [7:0] h, l);
		bus(1'b1, fas_pkg::OFS_PAGE_ADDR_HIGH, h);
		bus(1'b1, fas_pkg::OFS_PAGE_ADDR_LOW, l);
	endtask : page

	task code_chk(input logic [15:0] a, input logic x, input logic [7:0] e,
		input logic b);
		@(posedge clk);
		crd <= 1'b1;
		cadr <= a;
		ext <= x;
		@(posedge clk);
		crd <= 1'b0;
		ext <= 1'b0;
		@(negedge clk);
		`CHK(cdat, e)
		`CHK(cblk, b)
	endtask : code_chk

	task pp_chk(input logic [1:0] op, input logic [7:0] d, e, input logic r);
		fas_prog_host_inst.pp_op(op, 16'h0000, d);
		@(negedge clk);
		if (op == fas_pkg::OP_READ)
			`CHK(pp_q, e)
		`CHK(pp_ref, r)
	endtask : pp_chk

	task erase_code;
		fas_prog_host_inst.pp_op(fas_pkg::OP_CODE_ERASE, 16'h0000, 8'h00);
	endtask : erase_code

	task do_reset(input logic s);
		@(posedge clk);
		strap <= s;
		rst <= 1'b1;
		repeat (4)
			@(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
	endtask : do_reset

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task t_regs;
		rd_chk(fas_pkg::OFS_FLASH_COMMAND, ALL, 32'h0000_0000);
		rd_chk(fas_pkg::OFS_PAGE_DATA3, ALL, 32'h0000_0000);
		page(8'h03, 8'hFF);
		rd_chk(fas_pkg::OFS_PAGE_ADDR_HIGH, ALL, 32'h0000_0003);
		rd_chk(fas_pkg::OFS_PAGE_ADDR_LOW, ALL, 32'h0000_00FF);
		bus(1'b1, fas_pkg::OFS_PAGE_DATA2, 8'h3C);
		rd_chk(fas_pkg::OFS_PAGE_DATA2, ALL, 32'h0000_003C);
		bus(1'b1, 5'h02, 8'h77);
		rd_chk(5'h02, ALL, 32'h0000_0000);
	endtask : t_regs

	task t_parallel;
		erase_code();
		pp_chk(fas_pkg::OP_PROGRAM, 8'h5A, 8'h00, 1'b0);
		code_chk(16'h0000, 1'b0, 8'h5A, 1'b0);
		fas_prog_host_inst.pp_op(fas_pkg::OP_SET_SECURITY, 16'h0000, 8'h01);
		rd_chk(fas_pkg::OFS_STATUS, 32'h0000_000E, 32'h0000_0002);
		pp_chk(fas_pkg::OP_PROGRAM, 8'h00, 8'h00, 1'b1);
		pp_chk(fas_pkg::OP_READ, 8'h00, 8'h5A, 1'b0);
		code_chk(16'h0000, 1'b1, 8'h5A, 1'b0);
		fas_prog_host_inst.pp_op(fas_pkg::OP_SET_SECURITY, 16'h0000, 8'h02);
		rd_chk(fas_pkg::OFS_STATUS, 32'h0000_000E, 32'h0000_0006);
		pp_chk(fas_pkg::OP_READ, 8'h00, 8'hFF, 1'b1);
		code_chk(16'h0000, 1'b1, 8'hFF, 1'b1);
		@(posedge clk);
		ext <= 1'b1;
		cmd(fas_pkg::CMD_READ);
		rd_chk(fas_pkg::OFS_STATUS, 32'h0000_0020, 32'h0000_0020);
		@(posedge clk);
		ext <= 1'b0;
		erase_code();
		rd_chk(fas_pkg::OFS_STATUS, 32'h0000_0006, 32'h0000_0000);
	endtask : t_parallel

	task t_data;
		cmd(fas_pkg::CMD_ERASE_ALL);
		page(8'h03, 8'hFF);
		for (int i = 0; i < 4; i++)
			bus(1'b1, fas_pkg::OFS_PAGE_DATA0 + 5'(4 * i), 8'(8'h11 * (i + 1)));
		cmd(fas_pkg::CMD_WRITE);
		page(8'h00, 8'h00);
		cmd(fas_pkg::CMD_READ);
		rd_chk(fas_pkg::OFS_PAGE_DATA0, ALL, 32'h0000_00FF);
		page(8'h03, 8'hFF);
		cmd(fas_pkg::CMD_READ);
		for (int i = 0; i < 4; i++)
			rd_chk(fas_pkg::OFS_PAGE_DATA0 + 5'(4 * i), ALL, 32'(8'h11 * (i + 1)));
		cmd(fas_pkg::CMD_VERIFY);
		rd_chk(fas_pkg::OFS_FLASH_COMMAND, ALL, 32'h0000_0000);
		bus(1'b1, fas_pkg::OFS_PAGE_DATA1, 8'h00);
		cmd(fas_pkg::CMD_VERIFY);
		rd_chk(fas_pkg::OFS_FLASH_COMMAND, ALL, 32'(fas_pkg::VERIFY_FAIL));
		cmd(fas_pkg::CMD_ERASE_PAGE);
		cmd(fas_pkg::CMD_READ);
		rd_chk(fas_pkg::OFS_PAGE_DATA3, ALL, 32'h0000_00FF);
	endtask : t_data

	task t_user;
		cmd(fas_pkg::CMD_USER_PROGRAM_WRITE);
		rd_chk(fas_pkg::OFS_STATUS, 32'h0000_0001, 32'h0000_0001);
		bus(1'b1, fas_pkg::OFS_PAGE_DATA0, 8'hA5);
		page(8'hDF, 8'hFF);
		cmd(fas_pkg::CMD_WRITE_BYTE);
		code_chk(16'hDFFF, 1'b0, 8'hA5, 1'b0);
		page(8'hDF, 8'hC0);
		cmd(fas_pkg::CMD_ERASE_PAGE);
		code_chk(16'hDFFF, 1'b0, 8'hFF, 1'b0);
		page(8'hE0, 8'h00);
		cmd(fas_pkg::CMD_WRITE_BYTE);
		code_chk(16'hE000, 1'b0, 8'hFF, 1'b0);
		page(8'h00, 8'h00);
		cmd(fas_pkg::CMD_WRITE_BYTE);
		code_chk(16'h0000, 1'b0, 8'hA5, 1'b0);
		cmd(fas_pkg::CMD_ERASE_ALL);
		code_chk(16'h0000, 1'b0, 8'hFF, 1'b0);
		cmd(fas_pkg::CMD_LEAVE_USER_WRITE);
		rd_chk(fas_pkg::OFS_STATUS, 32'h0000_0001, 32'h0000_0000);
		page(8'h00, 8'h00);
		cmd(fas_pkg::CMD_WRITE_BYTE);
		code_chk(16'h0000, 1'b0, 8'hFF, 1'b0);
		bus(1'b1, fas_pkg::OFS_PAGE_DATA0, 8'h00);
		cmd(fas_pkg::CMD_READ_BYTE);
		rd_chk(fas_pkg::OFS_PAGE_DATA0, ALL, 32'h0000_00A5);
	endtask : t_user

	task t_download;
		do_reset(1'b0);
		`CHK(dl_mode, 1'b1)
		fas_prog_host_inst.dl_cmd(fas_pkg::OP_SET_SECURITY, 8'h05);
		rd_chk(fas_pkg::OFS_STATUS, 32'h0000_001A, 32'h0000_001A);
		fas_prog_host_inst.dl_cmd(fas_pkg::OP_CODE_ERASE, 8'h00);
		rd_chk(fas_pkg::OFS_STATUS, 32'h0000_000A, 32'h0000_0008);
		fas_prog_host_inst.dl_cmd(fas_pkg::OP_PROGRAM, 8'h3C);
		code_chk(16'h0000, 1'b0, 8'h3C, 1'b0);
		do_reset(1'b0);
		`CHK(dl_mode, 1'b0)
		erase_code();
		do_reset(1'b0);
		`CHK(dl_mode, 1'b1)
		do_reset(1'b1);
		`CHK(dl_mode, 1'b0)
	endtask : t_download

	initial
	begin
		repeat (4)
			@(posedge clk);
		rst <= 1'b0;
		por <= 1'b0;
		t_regs();
		t_parallel();
		t_data();
		t_user();
		t_download();
		print_verdict();
	end
endmodule : flash_access_and_security_test
